// ---- rtl/event_buffer_cfg.svh ----
// Constants for the event recording and reporting unit
`ifndef EVENT_BUFFER_CFG_SVH
`define EVENT_BUFFER_CFG_SVH

`define EVB_DEPTH 100
`define EVB_BATCH 5
// Channels
`define EVB_CH_SYS 2'h0
`define EVB_CH_ONE 2'h1
`define EVB_CH_TWO 2'h2
// Event codes of the system channel
`define EVB_CODE_RESTART 6'h32
`define EVB_CODE_OVERFLOW 6'h33
`define EVB_CODE_THERMAL 6'h07
`define EVB_SYS_FIX_FIRST 6'h01
`define EVB_SYS_FIX_LAST 6'h07
`define EVB_SYS_MSK_FIRST 6'h1f
`define EVB_SYS_MSK_LAST 6'h24
// Channel 1 mask ranges
`define EVB_C1A_FIRST 6'h01
`define EVB_C1A_LAST 6'h0e
`define EVB_C1B_FIRST 6'h0f
`define EVB_C1B_LAST 6'h1a
`define EVB_C1C_FIRST 6'h1b
`define EVB_C1C_LAST 6'h26
// Channel 2 mask ranges
`define EVB_C2A_FIRST 6'h01
`define EVB_C2A_LAST 6'h0a
`define EVB_C2B_FIRST 6'h0b
`define EVB_C2B_LAST 6'h14
`define EVB_C2C_FIRST 6'h15
`define EVB_C2C_LAST 6'h1c
// Mask reset values
`define EVB_RST_SYS 6'h01
`define EVB_RST_C1A 14'h1054
`define EVB_RST_C1B 12'h555
`define EVB_RST_C1C 12'h155
`define EVB_RST_C2A 10'h003
`define EVB_RST_C2B 10'h000
`define EVB_RST_C2C 8'h00

`endif

// ---- rtl/event_buffer_pkg.sv ----
// Types shared by the event recording and reporting unit
package event_buffer_pkg;
   typedef enum logic [1:0] {
      CMD_FETCH = 2'b00,
      CMD_REFETCH = 2'b01,
      CMD_CLEAR = 2'b10,
      CMD_NONE = 2'b11
   } cmd_t;
   typedef enum logic [2:0] {
      SEL_SYS = 3'b000,
      SEL_C1A = 3'b001,
      SEL_C1B = 3'b010,
      SEL_C1C = 3'b011,
      SEL_C2A = 3'b100,
      SEL_C2B = 3'b101,
      SEL_C2C = 3'b110,
      SEL_NONE = 3'b111
   } mask_sel_t;
   typedef enum logic [0:0] {
      ST_IDLE = 1'b0,
      ST_SEND = 1'b1
   } seq_state_t;
endpackage

// ---- rtl/event_ring_store.sv ----
// Ring store of event entries with bulk drop and offset read
`timescale 1ns/1ps
`include "event_buffer_cfg.svh"
module event_ring_store #(
   parameter int WIDTH = 8,
   parameter int DEPTH = `EVB_DEPTH,
   parameter int CW = $clog2(DEPTH + 1)
) (
   input wire logic sys_clk, // System clock
   input wire logic rst, // Synchronous reset
   input wire logic push, // Append one entry
   input wire logic [WIDTH-1:0] wdata, // Entry to append
   input wire logic [CW-1:0] drop, // Entries removed from the head
   input wire logic [CW-1:0] rd_ofs, // Read offset from the head
   output logic [WIDTH-1:0] rd_data, // Entry at the offset
   output logic [CW-1:0] count, // Entries held
   output logic full // No room left
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_ff [DEPTH];
   logic [AW-1:0] head_ff;
   logic [CW-1:0] cnt_ff;
   logic [AW-1:0] wr_idx;
   logic [AW-1:0] rd_idx;
   logic [AW-1:0] nxt_head;

   // Modulo over the ring size
   function automatic logic [AW-1:0] wrap(input logic [AW:0] sum);
      wrap = (sum >= (AW+1)'(DEPTH)) ? AW'(sum - (AW+1)'(DEPTH)) : AW'(sum);
   endfunction

   // Pointer arithmetic
   assign wr_idx = wrap({1'b0, head_ff} + (AW+1)'(cnt_ff));
   assign rd_idx = wrap({1'b0, head_ff} + (AW+1)'(rd_ofs));
   assign nxt_head = wrap({1'b0, head_ff} + (AW+1)'(drop));
   assign rd_data = mem_ff[rd_idx];
   assign count = cnt_ff;
   assign full = (cnt_ff == CW'(DEPTH));

   // Entry storage, one register per slot
   genvar gi;
   generate
      for (gi = 0; gi < DEPTH; gi++) begin : g_slot
         always_ff @(posedge sys_clk) begin
            if (push && (wr_idx == AW'(gi))) mem_ff[gi] <= wdata;
         end
      end
   endgenerate

   // Head and fill level; the caller never pushes when full
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         head_ff <= '0;
         cnt_ff <= '0;
      end else begin
         head_ff <= nxt_head;
         cnt_ff <= cnt_ff - drop + CW'(push);
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   chk_cap_limit: assert property (cnt_ff <= CW'(DEPTH))
      else $error("ring fill level above capacity");
endmodule // event_ring_store

// ---- rtl/event_buffer_reporting.sv ----
// Event recording, masking and batched reporting to the remote master
`timescale 1ns/1ps
`include "event_buffer_cfg.svh"
module event_buffer_reporting #(
   parameter int DEPTH = `EVB_DEPTH,
   parameter int BATCH = `EVB_BATCH
) (
   input wire logic sys_clk, // System clock
   input wire logic rst, // Synchronous reset, active high
   input wire logic evt_valid, // Source event strobe
   input wire logic [1:0] evt_chan, // Source event channel
   input wire logic [5:0] evt_code, // Source event code
   input wire logic thermal_wr, // Thermal level written over link
   input wire logic param_wr, // Mask write strobe
   input wire event_buffer_pkg::mask_sel_t param_sel, // Mask selected
   input wire logic [13:0] param_wdata, // Mask write value
   output logic [13:0] param_rdata_ff, // Selected mask value
   input wire logic cmd_valid, // Master command strobe
   input wire event_buffer_pkg::cmd_t cmd_code, // Master command
   output logic cmd_ready_ff, // Command accepted in the previous cycle
   output logic rsp_valid_ff, // Reported event strobe
   output logic [1:0] rsp_chan_ff, // Reported event channel
   output logic [5:0] rsp_code_ff, // Reported event code
   output logic rsp_done_ff // Batch complete pulse
);
   localparam int CW = $clog2(DEPTH + 1);

   event_buffer_pkg::seq_state_t state_ff, nxt_state;
   logic [5:0] m_sys_ff;
   logic [13:0] m_c1a_ff;
   logic [11:0] m_c1b_ff, m_c1c_ff;
   logic [9:0] m_c2a_ff, m_c2b_ff;
   logic [7:0] m_c2c_ff;
   logic restart_ff, ovf_ff, thermal_pend_ff;
   logic snap_rst_ff, snap_ovf_ff;
   logic [2:0] prev_cnt_ff, total_ff, idx_ff;
   logic [CW-1:0] fifo_cnt, avail, drop, rd_ofs;
   logic fifo_full;
   logic [7:0] rd_entry, wr_entry;

   // Range hit on a mask bit, used for every mask range
   function automatic logic mask_hit(input logic [5:0] code, input logic [5:0] first,
                                     input logic [5:0] last, input logic [13:0] mask);
      logic [5:0] ofs;
      ofs = code - first;
      mask_hit = (code >= first) && (code <= last) && mask[ofs[3:0]];
   endfunction

   // Event qualification per channel
   wire sys_fix = (evt_code >= `EVB_SYS_FIX_FIRST) && (evt_code <= `EVB_SYS_FIX_LAST);
   wire sys_en = sys_fix || mask_hit(evt_code, `EVB_SYS_MSK_FIRST, `EVB_SYS_MSK_LAST,
                                     {8'h00, m_sys_ff});
   wire c1_en = mask_hit(evt_code, `EVB_C1A_FIRST, `EVB_C1A_LAST, m_c1a_ff)
             || mask_hit(evt_code, `EVB_C1B_FIRST, `EVB_C1B_LAST, {2'h0, m_c1b_ff})
             || mask_hit(evt_code, `EVB_C1C_FIRST, `EVB_C1C_LAST, {2'h0, m_c1c_ff});
   wire c2_en = mask_hit(evt_code, `EVB_C2A_FIRST, `EVB_C2A_LAST, {4'h0, m_c2a_ff})
             || mask_hit(evt_code, `EVB_C2B_FIRST, `EVB_C2B_LAST, {4'h0, m_c2b_ff})
             || mask_hit(evt_code, `EVB_C2C_FIRST, `EVB_C2C_LAST, {6'h00, m_c2c_ff});
   wire evt_ok = evt_valid && (((evt_chan == `EVB_CH_SYS) && sys_en)
              || ((evt_chan == `EVB_CH_ONE) && c1_en)
              || ((evt_chan == `EVB_CH_TWO) && c2_en));

   // Store path; a pending thermal change waits for a free slot cycle
   wire thermal_store = thermal_pend_ff && !evt_ok;
   wire push_req = evt_ok || thermal_store;
   wire push = push_req && !fifo_full;
   wire ovf_set = push_req && fifo_full;
   assign wr_entry = evt_ok ? {evt_chan, evt_code} : {`EVB_CH_SYS, `EVB_CODE_THERMAL};

   // Command decode
   wire take = cmd_valid && (state_ff == event_buffer_pkg::ST_IDLE);
   wire take_fetch = take && (cmd_code == event_buffer_pkg::CMD_FETCH);
   wire take_refetch = take && (cmd_code == event_buffer_pkg::CMD_REFETCH);
   wire take_clear = take && (cmd_code == event_buffer_pkg::CMD_CLEAR);

   // Batch sizing: flags first, then buffered events up to the batch limit
   wire [2:0] nflags = 3'(restart_ff) + 3'(ovf_ff);
   wire [2:0] room = 3'(BATCH) - nflags;
   assign avail = fifo_cnt - CW'(prev_cnt_ff);
   wire [2:0] bcnt = (avail < CW'(room)) ? avail[2:0] : room;
   assign drop = take_fetch ? CW'(prev_cnt_ff) : '0;

   // Item selection during the send phase
   wire [2:0] nsnap = 3'(snap_rst_ff) + 3'(snap_ovf_ff);
   wire item_flag = idx_ff < nsnap;
   wire item_rst = item_flag && (idx_ff == 3'h0) && snap_rst_ff;
   assign rd_ofs = CW'(idx_ff - nsnap);
   wire [7:0] item = item_rst ? {`EVB_CH_SYS, `EVB_CODE_RESTART}
                   : item_flag ? {`EVB_CH_SYS, `EVB_CODE_OVERFLOW} : rd_entry;
   wire sending = (state_ff == event_buffer_pkg::ST_SEND) && (idx_ff < total_ff);
   assign nxt_state = take && !take_clear ? event_buffer_pkg::ST_SEND
                    : (state_ff == event_buffer_pkg::ST_SEND) && !sending
                    ? event_buffer_pkg::ST_IDLE : state_ff;

   // Mask readback selection
   wire [13:0] rd_mask = (param_sel == event_buffer_pkg::SEL_SYS) ? {8'h00, m_sys_ff}
      : (param_sel == event_buffer_pkg::SEL_C1A) ? m_c1a_ff
      : (param_sel == event_buffer_pkg::SEL_C1B) ? {2'h0, m_c1b_ff}
      : (param_sel == event_buffer_pkg::SEL_C1C) ? {2'h0, m_c1c_ff}
      : (param_sel == event_buffer_pkg::SEL_C2A) ? {4'h0, m_c2a_ff}
      : (param_sel == event_buffer_pkg::SEL_C2B) ? {4'h0, m_c2b_ff}
      : (param_sel == event_buffer_pkg::SEL_C2C) ? {6'h00, m_c2c_ff} : 14'h0000;

   event_ring_store #(.WIDTH(8), .DEPTH(DEPTH), .CW(CW)) u_store (
      .sys_clk(sys_clk),
      .rst(rst),
      .push(push),
      .wdata(wr_entry),
      .drop(drop),
      .rd_ofs(rd_ofs),
      .rd_data(rd_entry),
      .count(fifo_cnt),
      .full(fifo_full)
   );

   // Channel masks, written by the master
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         m_sys_ff <= `EVB_RST_SYS;
         m_c1a_ff <= `EVB_RST_C1A;
         m_c1b_ff <= `EVB_RST_C1B;
         m_c1c_ff <= `EVB_RST_C1C;
         m_c2a_ff <= `EVB_RST_C2A;
         m_c2b_ff <= `EVB_RST_C2B;
         m_c2c_ff <= `EVB_RST_C2C;
      end else if (param_wr) begin
         case (param_sel)
            event_buffer_pkg::SEL_SYS: m_sys_ff <= param_wdata[5:0];
            event_buffer_pkg::SEL_C1A: m_c1a_ff <= param_wdata;
            event_buffer_pkg::SEL_C1B: m_c1b_ff <= param_wdata[11:0];
            event_buffer_pkg::SEL_C1C: m_c1c_ff <= param_wdata[11:0];
            event_buffer_pkg::SEL_C2A: m_c2a_ff <= param_wdata[9:0];
            event_buffer_pkg::SEL_C2B: m_c2b_ff <= param_wdata[9:0];
            event_buffer_pkg::SEL_C2C: m_c2c_ff <= param_wdata[7:0];
            default: m_sys_ff <= m_sys_ff;
         endcase
      end
   end

   // Sticky flags; a new overflow beats a clear in the same cycle
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         restart_ff <= 1'b1;
         ovf_ff <= 1'b0;
         thermal_pend_ff <= 1'b0;
      end else begin
         restart_ff <= restart_ff && !take_clear;
         ovf_ff <= ovf_set || (ovf_ff && !take_clear);
         thermal_pend_ff <= thermal_wr || (thermal_pend_ff && !thermal_store);
      end
   end

   // Batch record; a refetch leaves it untouched so the batch repeats
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         snap_rst_ff <= 1'b0;
         snap_ovf_ff <= 1'b0;
         prev_cnt_ff <= 3'h0;
         total_ff <= 3'h0;
      end else if (take_fetch) begin
         snap_rst_ff <= restart_ff;
         snap_ovf_ff <= ovf_ff;
         prev_cnt_ff <= bcnt;
         total_ff <= nflags + bcnt;
      end
   end

   // Sequencer and response outputs
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         state_ff <= event_buffer_pkg::ST_IDLE;
         idx_ff <= 3'h0;
         cmd_ready_ff <= 1'b0;
         rsp_valid_ff <= 1'b0;
         rsp_chan_ff <= 2'h0;
         rsp_code_ff <= 6'h00;
         rsp_done_ff <= 1'b0;
         param_rdata_ff <= 14'h0000;
      end else begin
         state_ff <= nxt_state;
         idx_ff <= take ? 3'h0 : (sending ? idx_ff + 3'h1 : idx_ff);
         cmd_ready_ff <= take;
         rsp_valid_ff <= sending;
         rsp_chan_ff <= sending ? item[7:6] : 2'h0;
         rsp_code_ff <= sending ? item[5:0] : 6'h00;
         rsp_done_ff <= (state_ff == event_buffer_pkg::ST_SEND) && !sending;
         param_rdata_ff <= rd_mask;
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);

   // Helper: fill level expected after a fetch drop
   wire [CW-1:0] cnt_after_fetch = fifo_cnt - CW'(prev_cnt_ff) + CW'(push);

   chk_batch_limit: assert property (total_ff <= 3'(BATCH))
      else $error("batch larger than five events");
   chk_fetch_drop: assert property (take_fetch |=> fifo_cnt == $past(cnt_after_fetch))
      else $error("fetch did not remove the previous batch");
   chk_flags_hold: assert property (restart_ff && !take_clear |=> restart_ff)
      else $error("restart flag lost without clear");
   chk_refetch_same: assert property (take_refetch |=> (total_ff == $past(total_ff))
      && (fifo_cnt == $past(fifo_cnt) + CW'($past(push))))
      else $error("refetch changed the batch or erased events");
   chk_mask_gate: assert property (evt_valid && (evt_chan == `EVB_CH_ONE) && !c1_en
      && !thermal_pend_ff && !fifo_full |=> fifo_cnt == $past(fifo_cnt) - $past(drop))
      else $error("masked event was stored");
   chk_always_sys: assert property (evt_valid && (evt_chan == `EVB_CH_SYS) && sys_fix
      && !fifo_full |-> push)
      else $error("unmaskable system event not stored");
   chk_thermal_evt: assert property (thermal_wr ##1 !evt_ok |-> thermal_store)
      else $error("thermal write did not raise its event");
   chk_reset_start: assert property ($past(rst) |-> restart_ff && !ovf_ff
      && (fifo_cnt == '0))
      else $error("state after reset not empty with restart");
   chk_ovf_sticky: assert property (push_req && fifo_full
      |=> ovf_ff ##1 (ovf_ff || $past(take_clear)))
      else $error("overflow not flagged on full buffer");

   cov_fetch_five: cover property (take_fetch ##1 rsp_valid_ff[*5] ##1 rsp_done_ff);
   cov_refetch: cover property (take_fetch ##[1:20] take_refetch);
   cov_clear: cover property (take_clear && ovf_ff);
   cov_overflow: cover property (ovf_set);
endmodule // event_buffer_reporting

// ---- dv/remote_master_model.sv ----
// Remote master model: issues one command, collects the returned batch
`timescale 1ns/1ps
module remote_master_model (
   input wire logic sys_clk, // System clock
   input wire logic rst, // Synchronous reset
   input wire logic do_cmd, // Bench request pulse
   input wire event_buffer_pkg::cmd_t do_code, // Command wanted
   input wire logic [3:0] gap, // Idle cycles before the command
   output event_buffer_pkg::cmd_t cmd_code, // Command to the device
   output logic cmd_valid, // Command strobe
   input wire logic cmd_ready_ff, // Command taken
   input wire logic rsp_valid_ff, // Reported event strobe
   input wire logic [1:0] rsp_chan_ff, // Reported channel
   input wire logic [5:0] rsp_code_ff, // Reported code
   input wire logic rsp_done_ff, // Batch end
   output logic busy, // Command in flight
   output logic [3:0] got_n, // Events in the last batch
   output logic [7:0] got [0:7] // Channel and code per event
);
   event_buffer_pkg::cmd_t code;
   int n;
   int k;

   // One command at a time; a new one never overlaps a streaming batch
   initial begin
      cmd_valid = 1'b0;
      cmd_code = event_buffer_pkg::CMD_NONE;
      busy = 1'b0;
      got_n = 4'h0;
      forever begin
         @(posedge sys_clk);
         if (do_cmd && !rst) begin
            code = do_code;
            busy <= 1'b1;
            n = 0;
            k = 0;
            repeat (gap) @(posedge sys_clk);
            cmd_valid <= 1'b1;
            cmd_code <= code;
            // Hold the request until the taken pulse is sampled
            do begin
               @(posedge sys_clk);
               k++;
            end while (cmd_ready_ff !== 1'b1 && k < 40);
            cmd_valid <= 1'b0;
            cmd_code <= event_buffer_pkg::CMD_NONE;
            k = 0;
            if (code != event_buffer_pkg::CMD_CLEAR) begin
               // Gather events until the batch end pulse
               do begin
                  @(posedge sys_clk);
                  if (rsp_valid_ff === 1'b1 && n < 8)
                     got[n] <= {rsp_chan_ff, rsp_code_ff};
                  if (rsp_valid_ff === 1'b1)
                     n++;
                  k++;
               end while (rsp_done_ff !== 1'b1 && k < 40);
            end else begin
               // Clear has no batch; let its second taken pulse pass
               @(posedge sys_clk);
            end
            got_n <= n[3:0];
            busy <= 1'b0;
         end
      end
   end
endmodule // remote_master_model

// ---- dv/event_buffer_reporting_test.sv ----
// Self-checking bench for the event recording and reporting unit
`timescale 1ns/1ps
module event_buffer_reporting_test;
   logic sys_clk;
   logic rst;
   logic evt_valid;
   logic [1:0] evt_chan;
   logic [5:0] evt_code;
   logic thermal_wr;
   logic param_wr;
   event_buffer_pkg::mask_sel_t param_sel;
   logic [13:0] param_wdata;
   logic [13:0] param_rdata_ff;
   logic cmd_valid;
   event_buffer_pkg::cmd_t cmd_code;
   logic cmd_ready_ff;
   logic rsp_valid_ff;
   logic [1:0] rsp_chan_ff;
   logic [5:0] rsp_code_ff;
   logic rsp_done_ff;
   logic do_cmd;
   event_buffer_pkg::cmd_t do_code;
   logic [3:0] gap;
   logic busy;
   logic [3:0] got_n;
   logic [7:0] got [0:7];
   logic [7:0] exp_q [$];
   logic [13:0] rst_row [0:7];
   int fail_count;
   int cmp_count;
   int total;
   int i;
   int done_count;

   event_buffer_reporting i_dut (.sys_clk, .rst, .evt_valid, .evt_chan, .evt_code, .thermal_wr,
      .param_wr, .param_sel, .param_wdata, .param_rdata_ff, .cmd_valid, .cmd_code, .cmd_ready_ff,
      .rsp_valid_ff, .rsp_chan_ff, .rsp_code_ff, .rsp_done_ff);
   remote_master_model i_master (.sys_clk, .rst, .do_cmd, .do_code, .gap, .cmd_code, .cmd_valid,
      .cmd_ready_ff, .rsp_valid_ff, .rsp_chan_ff, .rsp_code_ff, .rsp_done_ff, .busy, .got_n, .got);

   // Batch end pulses; the model alone would not notice a missing one
   always @(posedge sys_clk) begin
      if (rsp_done_ff === 1'b1) done_count <= done_count + 1;
   end

   // 200 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end

   task automatic chk(input string what, input logic [13:0] exp, input logic [13:0] seen);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Batch length first, then each event in order
   task automatic chk_batch(input string what);
      chk({what, " length"}, 14'(exp_q.size()), {10'h000, got_n});
      for (int j = 0; j < exp_q.size(); j++)
         chk(what, {6'h00, exp_q[j]}, {6'h00, got[j]});
   endtask

   task automatic cmd(input event_buffer_pkg::cmd_t c);
      int k;
      k = 0;
      @(posedge sys_clk);
      do_code <= c;
      do_cmd <= 1'b1;
      @(posedge sys_clk);
      do_cmd <= 1'b0;
      @(posedge sys_clk);
      while (busy !== 1'b0 && k < 60) begin
         @(posedge sys_clk);
         k++;
      end
   endtask

   // Back-to-back source events, one per cycle
   task automatic ev(input logic [1:0] ch, input logic [5:0] code, input int n);
      repeat (n) begin
         @(posedge sys_clk);
         evt_valid <= 1'b1;
         evt_chan <= ch;
         evt_code <= code;
      end
      @(posedge sys_clk);
      evt_valid <= 1'b0;
   endtask

   task automatic wr(input event_buffer_pkg::mask_sel_t sel, input logic [13:0] val);
      @(posedge sys_clk);
      param_wr <= 1'b1;
      param_sel <= sel;
      param_wdata <= val;
      @(posedge sys_clk);
      param_wr <= 1'b0;
      repeat (2) @(posedge sys_clk);
   endtask

   task automatic do_reset();
      @(posedge sys_clk);
      rst <= 1'b1;
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
   endtask

   task automatic give_verdict();
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Hang guard, far above the expected run of well under a thousand cycles
   initial begin
      repeat (20000) @(posedge sys_clk);
      fail_count++;
      give_verdict();
   end

   initial begin
      rst = 1'b1;
      evt_valid = 1'b0;
      evt_chan = 2'h0;
      evt_code = 6'h00;
      thermal_wr = 1'b0;
      param_wr = 1'b0;
      param_sel = event_buffer_pkg::SEL_NONE;
      param_wdata = 14'h0000;
      do_cmd = 1'b0;
      do_code = event_buffer_pkg::CMD_NONE;
      gap = 4'h0;
      fail_count = 0;
      cmp_count = 0;
      done_count = 0;
      rst_row = '{14'h0001, 14'h1054, 14'h0555, 14'h0155, 14'h0003, 14'h0000, 14'h0000, 14'h0000};
      do_reset();
      // Ordinary cases: one row per mask select, reset value beside it
      for (i = 0; i < 8; i++) begin
         @(posedge sys_clk);
         param_sel <= event_buffer_pkg::mask_sel_t'(i[2:0]);
         repeat (2) @(posedge sys_clk);
         chk("mask reset", rst_row[i], param_rdata_ff);
      end
      $display("test mask reset values done");
      exp_q = '{8'h32};
      cmd(event_buffer_pkg::CMD_FETCH);
      chk_batch("restart only");
      $display("test restart done");
      // Masked-out, enabled and always-kept events, then a thermal write
      ev(2'h1, 6'h01, 1);
      ev(2'h1, 6'h03, 1);
      ev(2'h0, 6'h01, 1);
      ev(2'h0, 6'h1f, 1);
      ev(2'h0, 6'h20, 1);
      thermal_wr <= 1'b1;
      @(posedge sys_clk);
      thermal_wr <= 1'b0;
      repeat (2) @(posedge sys_clk);
      exp_q = '{8'h32, 8'h43, 8'h01, 8'h1f, 8'h07};
      cmd(event_buffer_pkg::CMD_FETCH);
      chk_batch("mixed batch");
      // Repeated refetch, the second one with a slow master
      for (i = 0; i < 2; i++) begin
         gap <= 4'(3 * i);
         cmd(event_buffer_pkg::CMD_REFETCH);
         chk_batch("refetch batch");
      end
      gap <= 4'h0;
      $display("test fetch and refetch done");
      cmd(event_buffer_pkg::CMD_CLEAR);
      exp_q = {};
      cmd(event_buffer_pkg::CMD_FETCH);
      chk_batch("after clear");
      $display("test clear done");
      wr(event_buffer_pkg::SEL_SYS, 14'h0002);
      chk("sys mask", 14'h0002, param_rdata_ff);
      ev(2'h0, 6'h1f, 1);
      ev(2'h0, 6'h20, 1);
      // Channel 1 and 2 ranges, kept or dropped by their reset masks
      ev(2'h2, 6'h01, 1);
      ev(2'h2, 6'h0b, 1);
      ev(2'h1, 6'h0f, 1);
      ev(2'h1, 6'h1b, 1);
      exp_q = '{8'h20, 8'h81, 8'h4f, 8'h5b};
      cmd(event_buffer_pkg::CMD_FETCH);
      chk_batch("new mask");
      $display("test mask write done");
      // Flush the last batch so the burst meets an empty buffer
      exp_q = {};
      cmd(event_buffer_pkg::CMD_FETCH);
      chk_batch("flush");
      // One event past capacity, then drain while the flag stays
      ev(2'h0, 6'h02, 101);
      total = 0;
      for (i = 0; i < 26; i++) begin
         cmd(event_buffer_pkg::CMD_FETCH);
         chk("overflow lead", 14'h0033, {6'h00, got[0]});
         total += int'(got_n) - 1;
      end
      chk("events kept", 14'h0064, 14'(total));
      cmd(event_buffer_pkg::CMD_CLEAR);
      exp_q = {};
      cmd(event_buffer_pkg::CMD_FETCH);
      chk_batch("overflow cleared");
      $display("test overflow done");
      // Second reset with an event pending: only restart survives
      ev(2'h0, 6'h01, 1);
      do_reset();
      exp_q = '{8'h32};
      cmd(event_buffer_pkg::CMD_FETCH);
      chk_batch("second reset");
      $display("test second reset done");
      chk("batch ends", 14'h0023, 14'(done_count));
      give_verdict();
   end
endmodule // event_buffer_reporting_test
